// ---- include/fsic_consts.vh ----
`ifndef FSIC_CONSTS_VH
`define FSIC_CONSTS_VH

// Register addresses on the byte port
`define FSIC_ADDR_EN      8'hA8
`define FSIC_ADDR_IPL     8'hB8
`define FSIC_ADDR_PRH     8'hB7
`define FSIC_ADDR_STAT    8'hC0
`define FSIC_ADDR_CLR     8'hC1
`define FSIC_ADDR_MASK    8'hC2

// Bit-access decode: group field and bit field of the address
`define FSIC_GRP_MSB      7
`define FSIC_GRP_LSB      3
`define FSIC_BSEL_MSB     2

// Field layout shared by enable and priority registers
`define FSIC_NSRC         5
`define FSIC_SRC_MSB      4
`define FSIC_BIT_MASTER   7
`define FSIC_EN_KEEP      8'h9F
`define FSIC_PR_KEEP      8'h1F

// Source indices, also the polling order inside one level
`define FSIC_SRC_EXT0     3'h0
`define FSIC_SRC_TMR0     3'h1
`define FSIC_SRC_EXT1     3'h2
`define FSIC_SRC_TMR1     3'h3
`define FSIC_SRC_SER      3'h4

// Reset values and fillers
`define FSIC_RST_BYTE     8'h00
`define FSIC_RST_SRC      5'h00
`define FSIC_RST_ISV      4'h0
`define FSIC_RST_VEC      3'h0
`define FSIC_RST_LVL      2'h0
`define FSIC_ONE8         8'h01
`define FSIC_ONE4         4'h1
`define FSIC_PAD3         3'h0

// Priority levels
`define FSIC_NLVL         4
`define FSIC_LVL_MSB      3
`define FSIC_LVL_TOP      2'h3

`endif

// ---- rtl/fsic_sticky.v ----
`include "fsic_consts.vh"

// Bank of sticky flags; a set in the clearing cycle wins
module fsic_sticky #(
   parameter W = `FSIC_NSRC
) (
   input  wire         clock,
   input  wire         rst_n,
   input  wire [W-1:0] set,   // Hardware event, one cycle
   input  wire [W-1:0] clr,   // Software clear, one cycle
   output wire [W-1:0] q      // Flag state
);

   reg [W-1:0] flag_r;        // Flag storage

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_flag
         // Each flag: set beats clear
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               flag_r[i] <= 1'b0;
            end else if (set[i]) begin
               flag_r[i] <= 1'b1;
            end else if (clr[i]) begin
               flag_r[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign q = flag_r;

endmodule

// ---- rtl/fsic_prio_sel.v ----
`include "fsic_consts.vh"

// Picks the pending source with the highest level, then by poll order
module fsic_prio_sel (
   input  wire [`FSIC_SRC_MSB:0] pend,     // Enabled pending sources
   input  wire [`FSIC_SRC_MSB:0] prio_hi,  // Upper level bits
   input  wire [`FSIC_SRC_MSB:0] prio_lo,  // Lower level bits
   output reg                    sel_vld,  // Some source pending
   output reg  [2:0]             sel_idx,  // Winning source
   output reg  [1:0]             sel_lvl   // Its level
);

   wire [1:0] lvl_w [0:`FSIC_SRC_MSB];     // Level per source

   genvar g;
   generate
      for (g = 0; g < `FSIC_NSRC; g = g + 1) begin : g_lvl
         // Upper bit from high register, lower from low register
         assign lvl_w[g] = {prio_hi[g], prio_lo[g]};
      end
   endgenerate

   integer i;
   // Scan from last to first poll slot; ties go to the earlier slot
   always @* begin
      sel_vld = 1'b0;
      sel_idx = `FSIC_RST_VEC;
      sel_lvl = `FSIC_RST_LVL;
      for (i = `FSIC_SRC_MSB; i >= 0; i = i - 1) begin
         if (pend[i] && (!sel_vld || lvl_w[i] >= sel_lvl)) begin
            sel_vld = 1'b1;
            sel_idx = i[2:0];
            sel_lvl = lvl_w[i];
         end
      end
   end

endmodule

// ---- rtl/fsic_top.v ----
// Strobed register access was left to the implementer.
`include "fsic_consts.vh"

// Function
// - Five request sources, each own vector
// - Source forwarded only while its enable set
// - Bit 7 master enable blocks every core request, not the event interrupt
// - Enable bits: serial, t1, x1, t0, x0
// - Level is high bit over low bit
// - Low priority bits share enable layout
// - Only strictly higher level preempts handler
// - Top level handler never preempted
// - Higher level presented first when simultaneous
// - Equal levels resolved by fixed polling
// - Reserved bits undefined; software writes zero
// - Enable register resets cleared, bit access
// - Low priority register resets cleared, bit access
module fsic_top (
   input  wire                   clock,      // Core clock
   input  wire                   rst_n,      // Asynchronous reset
   input  wire [7:0]             addr,       // Register address
   input  wire [7:0]             wdata,      // Write data
   input  wire                   wr_en,      // Write strobe
   input  wire                   rd_en,      // Read strobe
   input  wire                   bit_mode,   // Write touches one bit
   output wire [7:0]             rdata,      // Read data, next cycle
   input  wire [`FSIC_SRC_MSB:0] src_req,    // Peripheral requests
   output wire                   irq_req,    // Request to core
   output wire [2:0]             irq_vec,    // Vector index
   output wire [1:0]             irq_lvl,    // Level of request
   input  wire                   irq_ack,    // Core takes request
   input  wire                   irq_done,   // Handler returns
   output wire [`FSIC_LVL_MSB:0] in_service, // Levels in service
   output wire                   irq_out     // Event interrupt
);

   // Software-visible registers
   reg  [7:0]             en_r;       // Enable register
   reg  [7:0]             en_nxt;
   reg  [7:0]             ipl_r;      // Low priority bits
   reg  [7:0]             ipl_nxt;
   reg  [7:0]             prh_r;      // High priority bits
   reg  [7:0]             prh_nxt;
   reg  [`FSIC_SRC_MSB:0] mask_r;     // Event interrupt enables
   reg  [7:0]             rdata_r;    // Read data holder
   reg  [7:0]             rdata_nxt;

   // Core-facing state
   reg  [`FSIC_LVL_MSB:0] isv_r;      // One bit per active level
   reg  [`FSIC_LVL_MSB:0] isv_nxt;
   reg                    req_r;      // Presented request
   reg                    req_nxt;
   reg  [2:0]             vec_r;      // Presented vector
   reg  [2:0]             vec_nxt;
   reg  [1:0]             lvl_r;      // Presented level
   reg  [1:0]             lvl_nxt;
   reg  [`FSIC_SRC_MSB:0] src_prev_r; // Requests one cycle ago

   // Decode and selection wires
   wire                   grp_en;     // Bit write hits enables
   wire                   grp_ipl;    // Bit write hits low priority bits
   wire [2:0]             bsel;       // Selected bit
   wire                   wr_enr;     // Enable register write
   wire                   wr_ipl;     // Low priority write
   wire                   wr_prh;     // High priority write

   // Bit-accessible addresses held as sized constants so fields can be sliced
   localparam [7:0]       en_addr  = `FSIC_ADDR_EN;
   localparam [7:0]       ipl_addr = `FSIC_ADDR_IPL;
   wire                   wr_clr;     // Status clear write
   wire                   wr_mask;    // Mask write
   wire [`FSIC_SRC_MSB:0] src_en;     // Individual enables
   wire                   master_irq_enable;
   wire [`FSIC_SRC_MSB:0] pend;       // Forwardable sources
   wire                   sel_vld;    // Selector found one
   wire [2:0]             sel_idx;    // Selector winner
   wire [1:0]             sel_lvl;    // Selector level
   wire [`FSIC_SRC_MSB:0] evt;        // Request rising edges
   wire [`FSIC_SRC_MSB:0] clr_bits;   // Status clears
   wire [`FSIC_SRC_MSB:0] stat;       // Sticky status
   reg                    act_any;    // Some level in service
   reg  [1:0]             act_lvl;    // Highest level in service
   reg  [`FSIC_LVL_MSB:0] top_bit;    // One-hot of active level
   reg                    take;       // Ack of presented request

   // Merge a byte or a single-bit write into a register image
   function [7:0] fsic_merge;
      input [7:0] cur;
      input [7:0] keep;
      input       bm;
      input [2:0] bs;
      input [7:0] wd;
      reg   [7:0] onehot;
      begin
         onehot = `FSIC_ONE8 << bs;
         if (bm) begin
            fsic_merge = ((cur & ~onehot) | (wd[0] ? onehot : `FSIC_RST_BYTE)) & keep;
         end else begin
            fsic_merge = wd & keep;
         end
      end
   endfunction

   // Bit-access group and bit select
   assign grp_en  = (addr[`FSIC_GRP_MSB:`FSIC_GRP_LSB] ==
                     en_addr[`FSIC_GRP_MSB:`FSIC_GRP_LSB]);
   assign grp_ipl = (addr[`FSIC_GRP_MSB:`FSIC_GRP_LSB] ==
                     ipl_addr[`FSIC_GRP_MSB:`FSIC_GRP_LSB]);
   assign bsel    = addr[`FSIC_BSEL_MSB:0];

   // Write decode: byte writes by address, bit writes by group
   assign wr_enr  = wr_en && (bit_mode ? grp_en : (addr == `FSIC_ADDR_EN));
   assign wr_ipl  = wr_en && (bit_mode ? grp_ipl : (addr == `FSIC_ADDR_IPL));
   assign wr_prh  = wr_en && !bit_mode && (addr == `FSIC_ADDR_PRH);
   assign wr_clr  = wr_en && !bit_mode && (addr == `FSIC_ADDR_CLR);
   assign wr_mask = wr_en && !bit_mode && (addr == `FSIC_ADDR_MASK);

   // Next register images; reserved bits are never stored
   always @* begin
      en_nxt  = en_r;
      ipl_nxt = ipl_r;
      prh_nxt = prh_r;
      if (wr_enr) begin
         // Only master and five source bits are kept
         en_nxt = fsic_merge(en_r, `FSIC_EN_KEEP, bit_mode, bsel, wdata);
      end
      if (wr_ipl) begin
         // Only the five source bits are kept
         ipl_nxt = fsic_merge(ipl_r, `FSIC_PR_KEEP, bit_mode, bsel, wdata);
      end
      if (wr_prh) begin
         // Same layout as the low priority bits
         prh_nxt = fsic_merge(prh_r, `FSIC_PR_KEEP, 1'b0, bsel, wdata);
      end
   end

   // Register storage, cleared by reset
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         en_r   <= `FSIC_RST_BYTE;
         ipl_r  <= `FSIC_RST_BYTE;
         prh_r  <= `FSIC_RST_BYTE;
         mask_r <= `FSIC_RST_SRC;
      end else begin
         en_r  <= en_nxt;
         ipl_r <= ipl_nxt;
         prh_r <= prh_nxt;
         if (wr_mask) begin
            // Event interrupt enables
            mask_r <= wdata[`FSIC_SRC_MSB:0];
         end
      end
   end

   // Read mux; reserved and unmapped read as zero
   always @* begin
      rdata_nxt = `FSIC_RST_BYTE;
      case (addr)
         `FSIC_ADDR_EN: begin
            rdata_nxt = en_r;
         end
         `FSIC_ADDR_IPL: begin
            rdata_nxt = ipl_r;
         end
         `FSIC_ADDR_PRH: begin
            rdata_nxt = prh_r;
         end
         `FSIC_ADDR_STAT: begin
            rdata_nxt = {`FSIC_PAD3, stat};
         end
         `FSIC_ADDR_MASK: begin
            rdata_nxt = {`FSIC_PAD3, mask_r};
         end
         default: begin
            rdata_nxt = `FSIC_RST_BYTE;
         end
      endcase
   end

   // Read data stand for exactly the cycle after the strobe
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= `FSIC_RST_BYTE;
      end else if (rd_en) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= `FSIC_RST_BYTE;
      end
   end

   assign rdata = rdata_r;

   // Enable fields: five sources in the low bits, master on top
   assign src_en            = en_r[`FSIC_SRC_MSB:0];
   assign master_irq_enable = en_r[`FSIC_BIT_MASTER];

   // A source is forwardable only with both enables set
   assign pend = src_req & src_en & {`FSIC_NSRC{master_irq_enable}};

   // Level and poll-order arbitration over the five sources
   fsic_prio_sel u_sel (
      .pend    (pend),
      .prio_hi (prh_r[`FSIC_SRC_MSB:0]),
      .prio_lo (ipl_r[`FSIC_SRC_MSB:0]),
      .sel_vld (sel_vld),
      .sel_idx (sel_idx),
      .sel_lvl (sel_lvl)
   );

   // Core takes the request presented in this cycle
   always @* begin
      take = irq_ack && req_r;
   end

   // In-service update: return pops the top level, ack pushes a level
   always @* begin
      top_bit = `FSIC_RST_ISV;
      if (isv_r[3]) begin
         top_bit = `FSIC_ONE4 << 3;
      end else if (isv_r[2]) begin
         top_bit = `FSIC_ONE4 << 2;
      end else if (isv_r[1]) begin
         top_bit = `FSIC_ONE4 << 1;
      end else if (isv_r[0]) begin
         top_bit = `FSIC_ONE4;
      end
      isv_nxt = isv_r;
      if (irq_done) begin
         // Return ends the innermost handler
         isv_nxt = isv_nxt & ~top_bit;
      end
      if (take) begin
         // Accepted request opens a handler at its level
         isv_nxt = isv_nxt | (`FSIC_ONE4 << lvl_r);
      end
   end

   // Highest level still in service after this cycle
   always @* begin
      act_any = |isv_nxt;
      act_lvl = `FSIC_RST_LVL;
      if (isv_nxt[3]) begin
         act_lvl = 2'h3;
      end else if (isv_nxt[2]) begin
         act_lvl = 2'h2;
      end else if (isv_nxt[1]) begin
         act_lvl = 2'h1;
      end
   end

   // Present a request only if it outranks every running handler
   always @* begin
      req_nxt = 1'b0;
      vec_nxt = vec_r;
      lvl_nxt = lvl_r;
      if (sel_vld) begin
         vec_nxt = sel_idx;
         lvl_nxt = sel_lvl;
         if (!act_any) begin
            // Idle core takes any winner
            req_nxt = 1'b1;
         end else if (act_lvl == `FSIC_LVL_TOP) begin
            // Top level handler is never interrupted
            req_nxt = 1'b0;
         end else begin
            // Strictly higher level preempts, equal or lower waits
            req_nxt = (sel_lvl > act_lvl);
         end
      end
   end

   // Core-facing state registers
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         isv_r <= `FSIC_RST_ISV;
         req_r <= 1'b0;
         vec_r <= `FSIC_RST_VEC;
         lvl_r <= `FSIC_RST_LVL;
      end else begin
         isv_r <= isv_nxt;
         req_r <= req_nxt;
         vec_r <= vec_nxt;
         lvl_r <= lvl_nxt;
      end
   end

   assign irq_req    = req_r;
   assign irq_vec    = vec_r;
   assign irq_lvl    = lvl_r;
   assign in_service = isv_r;

   // Previous request levels for edge detection
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         src_prev_r <= `FSIC_RST_SRC;
      end else begin
         src_prev_r <= src_req;
      end
   end

   // Each new request raises its status event
   assign evt      = src_req & ~src_prev_r;
   assign clr_bits = wr_clr ? wdata[`FSIC_SRC_MSB:0] : `FSIC_RST_SRC;

   // Sticky status per source; an event beats a clear
   fsic_sticky #(
      .W (`FSIC_NSRC)
   ) u_stat (
      .clock (clock),
      .rst_n (rst_n),
      .set   (evt),
      .clr   (clr_bits),
      .q     (stat)
   );

   // Level interrupt while any enabled status bit stands
   assign irq_out = |(stat & mask_r);

endmodule

// ---- dv/fsic_asserts.sv ----
`include "fsic_consts.vh"

// Port-level checks on the interrupt controller
module fsic_asserts (
   input wire                   clock,      // Core clock
   input wire                   rst_n,      // Asynchronous reset
   input wire                   rd_en,      // Read strobe
   input wire [7:0]             rdata,      // Read data
   input wire [`FSIC_SRC_MSB:0] src_req,    // Peripheral requests
   input wire                   irq_req,    // Request to core
   input wire [2:0]             irq_vec,    // Vector index
   input wire [1:0]             irq_lvl,    // Presented level
   input wire                   irq_ack,    // Core takes request
   input wire                   irq_done,   // Handler returns
   input wire [`FSIC_LVL_MSB:0] in_service  // Levels in service
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Core takes a request with no return beside it
   sequence s_accept;
      irq_req && irq_ack && !irq_done;
   endsequence
   // Handler returns while something is in service
   sequence s_return;
      irq_done && !irq_ack && (in_service != 4'h0);
   endsequence
   rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
      else $error("read data not zero outside its slot");
   req_cause_a: assert property (irq_req |-> (($past(src_req) >> irq_vec) & 5'h01) != 5'h00)
      else $error("request presented without its source");
   vec_range_a: assert property (irq_req |-> irq_vec <= 3'h4)
      else $error("vector outside the five sources");
   strict_pre_a: assert property (irq_req |-> (in_service >> irq_lvl) == 4'h0)
      else $error("request not above active level");
   top_hold_a: assert property (in_service[3] |-> !irq_req)
      else $error("top level handler disturbed");
   accept_set_a: assert property (s_accept |=> in_service[$past(irq_lvl)])
      else $error("taken level not marked in service");
   done_pop_a: assert property (s_return |=> in_service < $past(in_service)
      && ($past(in_service) - in_service) > in_service)
      else $error("return did not clear highest level");
   ack_drop_a: assert property (s_accept |=> !irq_req || irq_lvl > $past(irq_lvl))
      else $error("request kept after being taken");
endmodule

bind fsic_top fsic_asserts i_chk (.clock(clock), .rst_n(rst_n), .rd_en(rd_en), .rdata(rdata),
   .src_req(src_req), .irq_req(irq_req), .irq_vec(irq_vec), .irq_lvl(irq_lvl),
   .irq_ack(irq_ack), .irq_done(irq_done), .in_service(in_service));

// ---- dv/fsic_core_model.sv ----
// Core side: takes requests after an optional delay, returns on command
module fsic_core_model (
   input  wire       clock,      // Core clock
   input  wire       rst_n,      // Asynchronous reset
   input  wire       irq_req,    // Request from controller
   input  wire [3:0] in_service, // Levels in service
   input  wire       ack_en,     // Take requests at all
   input  wire       slow,       // Wait three cycles before taking
   input  wire       ret,        // Finish the running handler
   output reg        irq_ack,    // One-cycle take pulse
   output reg        irq_done    // One-cycle return pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [1:0] wait_r; // Cycles left before taking
   // Take only a standing request; return only with a handler running
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 2'h0;
         irq_ack <= 1'b0;
         irq_done <= 1'b0;
      end else begin
         irq_done <= ret && (in_service != 4'h0);
         if (!irq_req || irq_ack) begin
            // Idle or just taken: reload the delay
            wait_r <= slow ? 2'h3 : 2'h0;
            irq_ack <= 1'b0;
         end else if (wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
         end else begin
            irq_ack <= ack_en;
         end
      end
   end
endmodule

// ---- dv/fsic_top_tb.sv ----
`include "fsic_consts.vh"

module fsic_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   reg        clock, rst_n, wr_en, rd_en, bit_mode, ack_en, slow, ret;
   reg  [7:0] addr, wdata;
   reg  [4:0] src_req;
   wire [7:0] rdata;
   wire       irq_req, irq_ack, irq_done, irq_out;
   wire [2:0] irq_vec;
   wire [1:0] irq_lvl;
   wire [3:0] in_service;
   int        err_count, n_compared, i;

   fsic_top i_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .bit_mode(bit_mode), .rdata(rdata), .src_req(src_req), .irq_req(irq_req),
      .irq_vec(irq_vec), .irq_lvl(irq_lvl), .irq_ack(irq_ack), .irq_done(irq_done),
      .in_service(in_service), .irq_out(irq_out));
   fsic_core_model i_core (.clock(clock), .rst_n(rst_n), .irq_req(irq_req),
      .in_service(in_service), .ack_en(ack_en), .slow(slow), .ret(ret), .irq_ack(irq_ack),
      .irq_done(irq_done));

   // Free-running core clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Compare one byte
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Compare request, level and vector together
   task automatic cki(input logic [7:0] exp);
      chk({irq_req, irq_lvl, 2'h0, irq_vec}, exp);
   endtask
   // One-cycle write
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bm);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      bit_mode <= bm;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      bit_mode <= 1'b0;
   endtask
   // One-cycle read, data checked in the following cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      @(negedge clock);
      chk(rdata, exp);
   endtask
   // Let requests and handshakes land
   task automatic settle;
      repeat (8) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic put(input logic [4:0] s);
      @(posedge clock);
      src_req <= s;
   endtask
   task automatic conclude;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Cut a hang short
   initial begin
      #200000;
      err_count++;
      conclude;
   end

   // Main sequence
   initial begin
      {rst_n, wr_en, rd_en, bit_mode, ack_en, slow, ret} = 7'h00;
      {addr, wdata, src_req} = 21'h0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      rd(8'hA8, 8'h00);
      rd(8'hB8, 8'h00);
      rd(8'h55, 8'h00);
      $display("test reset done");
      // Reserved bits written as zero; single-bit access
      wr(8'hA8, 8'h9F, 1'b0);
      rd(8'hA8, 8'h9F);
      wr(8'hAF, 8'h00, 1'b1);
      rd(8'hA8, 8'h1F);
      wr(8'hBC, 8'h01, 1'b1);
      rd(8'hB8, 8'h10);
      wr(8'hB8, 8'h00, 1'b0);
      put(5'h1F);
      settle;
      chk(irq_req, 8'h00);
      $display("test access done");
      // Each enable alone forwards only its own source
      for (i = 0; i < 5; i++) begin
         wr(8'hA8, 8'h80 | (8'h01 << i), 1'b0);
         settle;
         cki({5'h10, 3'(i)});
      end
      // Fixed poll order inside one level
      wr(8'hA8, 8'h9F, 1'b0);
      for (i = 0; i < 5; i++) begin
         put(5'h1F << i);
         settle;
         cki({5'h10, 3'(i)});
      end
      $display("test enable done");
      // Levels: serial 3, ext1 2, timer0 1, rest 0
      put(5'h1F);
      wr(8'hB7, 8'h14, 1'b0);
      wr(8'hB8, 8'h12, 1'b0);
      settle;
      cki(8'hE4);
      put(5'h0F);
      settle;
      cki(8'hC2);
      put(5'h0B);
      settle;
      cki(8'hA1);
      $display("test level done");
      // Nesting with a slow core
      wr(8'hB7, 8'h00, 1'b0);
      wr(8'hB8, 8'h00, 1'b0);
      put(5'h00);
      ack_en <= 1'b1;
      slow <= 1'b1;
      wr(8'hA8, 8'h81, 1'b0);
      put(5'h01);
      settle;
      chk(in_service, 8'h01);
      wr(8'hB8, 8'h02, 1'b0);
      wr(8'hA8, 8'h83, 1'b0);
      put(5'h03);
      settle;
      chk(in_service, 8'h03);
      wr(8'hB8, 8'h06, 1'b0);
      wr(8'hA8, 8'h87, 1'b0);
      put(5'h07);
      settle;
      chk(irq_req, 8'h00);
      wr(8'hB7, 8'h10, 1'b0);
      wr(8'hB8, 8'h16, 1'b0);
      wr(8'hA8, 8'h97, 1'b0);
      put(5'h17);
      settle;
      chk(in_service, 8'h0B);
      wr(8'hB7, 8'h14, 1'b0);
      settle;
      chk(irq_req, 8'h00);
      @(posedge clock);
      ret <= 1'b1;
      @(posedge clock);
      ret <= 1'b0;
      repeat (2) @(posedge clock);
      @(negedge clock);
      cki(8'hE2);
      settle;
      chk(in_service, 8'h0B);
      $display("test nesting done");
      // Second reset in mid-run, asserted on a rising edge
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rd(8'hA8, 8'h00);
      chk(in_service, 8'h00);
      // Sticky status, mask and clear
      put(5'h00);
      wr(8'hC1, 8'h1F, 1'b0);
      wr(8'hC2, 8'h01, 1'b0);
      put(5'h01);
      settle;
      rd(8'hC0, 8'h01);
      chk(irq_out, 8'h01);
      wr(8'hC2, 8'h00, 1'b0);
      settle;
      chk(irq_out, 8'h00);
      wr(8'hC2, 8'h01, 1'b0);
      wr(8'hC1, 8'h01, 1'b0);
      settle;
      rd(8'hC0, 8'h00);
      chk(irq_out, 8'h00);
      $display("test status done");
      conclude;
   end
endmodule
